// ---- phs_apb_host.sv ----
// APB master model of the management host.
// Assumes the slave answers with pready on pclk.
`timescale 1ns/100ps
`default_nettype none
module phs_apb_host (
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb
);
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pstrb = 4'hF;
	end
	// One transfer, entered just after a rising edge
	task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ---- phs_checker.sv ----
// Assertions on the status bank ports.
// Assumes the bind below reaches every instance.
`timescale 1ns/100ps
`default_nettype none
module phs_checker import phs_pkg::*; #(
	parameter int PADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire phs_line_t line_in
);
	// Decode of the completing transfer
	wire logic [9:0] idx = paddr[PHS_IDX_LSB +: 10];
	wire logic rd_done = pready && !pwrite;
	wire logic sts_rd = rd_done && idx == PHS_IDX_STS;
	wire logic mapped = idx inside {PHS_IDX_CTRL, PHS_IDX_WIN, PHS_IDX_FLD, PHS_IDX_STS};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_one_wait: assert property ($rose(psel && penable) |=> pready)
		else $error("pready not after one wait");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_map: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr wrong for index");
	a_live_bits: assert property (sts_rd |-> !prdata[15] &&
		prdata[14] == $past(line_in[14], 2) && prdata[5:0] == $past(line_in[5:0], 2))
		else $error("live status bits wrong");
	a_rxerr_set: assert property (sts_rd && $past(line_in.rx_err_evt, 2) |-> prdata[13])
		else $error("receive error not latched");
	a_pol_set: assert property (sts_rd && $past(line_in.pol_inverted, 2) |-> prdata[12])
		else $error("polarity not latched");
	a_fcs_set: assert property (sts_rd && $past(line_in[11], 2) |-> prdata[11])
		else $error("false carrier not latched");
	a_sigdet_low: assert property (sts_rd && !$past(line_in[10], 2) |-> !prdata[10])
		else $error("signal detect not latched low");
	a_dlock_low: assert property (sts_rd && !$past(line_in[9], 2) |-> !prdata[9])
		else $error("descrambler lock not latched low");
	a_page_set: assert property (sts_rd && $past(line_in[8], 2) |-> prdata[8])
		else $error("page received not latched");
	a_irq_set: assert property (sts_rd && $past(line_in[7], 2) |-> prdata[7])
		else $error("interrupt pending not latched");
	a_rfault_set: assert property (sts_rd && $past(line_in[6], 2) |-> prdata[6])
		else $error("remote fault not latched");
	a_fld_rsvd: assert property (rd_done |-> prdata[31:16] == 16'h0 &&
		(idx != PHS_IDX_FLD || (prdata[15:9] == 7'h0 && prdata[3:0] == 4'h0)))
		else $error("reserved read bits set");
endmodule
bind phs_status_regs phs_checker #(.PADDR_W(PADDR_W)) phs_checker_inst (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .line_in);
`default_nettype wire

// ---- phs_pkg.sv ----
// Constants and carrier types for the transceiver status and indirect access bank.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package phs_pkg;

	// Register indices; byte address is four times the index
	localparam logic [9:0] PHS_IDX_CTRL = 10'h00D;
	localparam logic [9:0] PHS_IDX_WIN = 10'h00E;
	localparam logic [9:0] PHS_IDX_FLD = 10'h00F;
	localparam logic [9:0] PHS_IDX_STS = 10'h010;
	localparam int PHS_IDX_LSB = 2;

	// Reset values
	localparam logic [15:0] PHS_WIN_RST = 16'h0010;
	localparam logic [15:0] PHS_FLD_RST = 16'h0000;
	localparam logic PHS_SPEED_RST = 1'b1;

	// Control layout: command in 15:14, device address in 4:0
	localparam int PHS_CMD_MSB = 15;
	localparam int PHS_CMD_LSB = 14;
	localparam int PHS_DEV_MSB = 4;
	localparam int PHS_DEV_LSB = 0;

	// Window access commands
	typedef enum logic [1:0] {
		PHS_CMD_ADDR = 2'h0,
		PHS_CMD_DATA = 2'h1,
		PHS_CMD_INC_RW = 2'h2,
		PHS_CMD_INC_WR = 2'h3
	} phs_cmd_t;

	// Accepted device addresses
	localparam logic [4:0] PHS_DEV_VEND = 5'h1F;
	localparam logic [4:0] PHS_DEV_MMD3 = 5'h03;
	localparam logic [4:0] PHS_DEV_MMD7 = 5'h07;
	localparam int PHS_NUM_SPACES = 3;

	// Fast link drop cause field position
	localparam int PHS_FLD_MSB = 8;
	localparam int PHS_FLD_LSB = 4;

	// Status word bit positions
	localparam int PHS_ST_MDIX = 14;
	localparam int PHS_ST_RXERR = 13;
	localparam int PHS_ST_POL = 12;
	localparam int PHS_ST_FCS = 11;
	localparam int PHS_ST_SIGDET = 10;
	localparam int PHS_ST_DLOCK = 9;
	localparam int PHS_ST_PAGE = 8;
	localparam int PHS_ST_IRQ = 7;
	localparam int PHS_ST_RFAULT = 6;
	localparam int PHS_ST_JAB = 5;
	localparam int PHS_ST_ANDONE = 4;
	localparam int PHS_ST_LOOP = 3;
	localparam int PHS_ST_DUPLEX = 2;
	localparam int PHS_ST_SPEED = 1;
	localparam int PHS_ST_LINK = 0;

	// Live conditions and events from the transceiver core
	typedef struct packed {
		logic mdix_swapped;
		logic rx_err_evt;
		logic pol_inverted;
		logic false_carrier_evt;
		logic signal_detect;
		logic descr_lock;
		logic page_rcvd_evt;
		logic irq_pending;
		logic remote_fault_evt;
		logic jabber;
		logic an_complete;
		logic mii_loopback;
		logic full_duplex;
		logic speed_10;
		logic link_up;
	} phs_line_t;

	// One-cycle read strobes of registers held elsewhere in the core
	typedef struct packed {
		logic rd_receive_error_counter;
		logic rd_ten_mbps_status_control;
		logic rd_false_carrier_counter;
		logic rd_negotiation_expansion_reg;
		logic rd_interrupt_status_reg;
		logic rd_basic_status_reg;
	} phs_clr_t;

	// Fast link drop causes, index matches field bit minus its low bit
	typedef struct packed {
		logic descr_sync_loss;
		logic rx_errors;
		logic line_code_errors;
		logic low_snr;
		logic energy_loss;
	} phs_fld_t;

endpackage

// ---- phs_status_regs.sv ----
// Status word, fast link drop cause and indirect window into three extended spaces.
// Assumes core inputs and clear strobes arrive on pclk; APB master per the published protocol.
`timescale 1ns/100ps
`default_nettype none

// How it works
// R1 - Window holds address when command is zero
// R2 - Cause field bits 8..4, one bit per cause
// R3 - Cause bit latches on enabled condition dropping link
// R4 - Bit 14 shows swapped media pairs
// R5 - Bit 13 latches receive error, cleared by counter read
// R6 - Bit 12 latches polarity flag, cleared by its register
// R7 - Bit 11 latches false carrier until counter read
// R8 - Bit 10 signal detect, latch low
// R9 - Bit 9 descrambler lock, latch low
// R10 - Bit 8 page received, cleared by expansion read
// R11 - Bit 7 interrupt pending, cleared by interrupt read
// R12 - Bit 6 remote fault, cleared by basic read
// R13 - Bit 5 jabber copy, not cleared by read
// R14 - Bit 4 negotiation complete
// R15 - Bit 3 loopback, bit 2 full duplex
// R16 - Bit 1 ten megabit, resets to one
// R17 - Bit 0 link copy, not cleared by read
// R18 - Command picks address, data, or increment flavour
// R19 - Only vendor, device 3, device 7 accepted
// R20 - New event beats coincident clearing read
module phs_status_regs import phs_pkg::*; #(
	parameter int EXT_AW = 4,
	parameter int PADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire phs_line_t line_in,
	input wire phs_clr_t clr_in,
	input wire phs_fld_t fld_enable,
	input wire phs_fld_t fld_cond,
	input wire logic link_drop
);

	localparam int EXT_DEPTH = 1 << EXT_AW;

	// Register state
	logic [15:0] ctrl;
	logic [15:0] win_addr;
	logic [PHS_FLD_MSB-PHS_FLD_LSB:0] fld_cause;
	logic st_rxerr, st_pol, st_fcs, st_sigdet, st_dlock;
	logic st_page, st_irq, st_rfault, st_speed;
	logic st_mdix, st_jab, st_andone, st_loop, st_duplex, st_link;
	logic [15:0] ext_mem [PHS_NUM_SPACES][EXT_DEPTH];

	// Bus phase decode
	logic [9:0] idx;
	logic access_done, wr_done, rd_done;
	logic hit_ctrl, hit_win, hit_fld, hit_sts, hit_any;
	logic wr_low, wr_high;
	assign idx = paddr[PHS_IDX_LSB +: 10];
	assign access_done = psel & penable & pready;
	assign wr_done = access_done & pwrite;
	assign rd_done = access_done & ~pwrite;
	assign hit_ctrl = (idx == PHS_IDX_CTRL);
	assign hit_win = (idx == PHS_IDX_WIN);
	assign hit_fld = (idx == PHS_IDX_FLD);
	assign hit_sts = (idx == PHS_IDX_STS);
	assign hit_any = hit_ctrl | hit_win | hit_fld | hit_sts;
	assign wr_low = pstrb[0];
	assign wr_high = pstrb[1];

	// Window steering from the control register
	phs_cmd_t cmd;
	logic [4:0] devad;
	logic dev_ok;
	logic [1:0] space;
	logic [EXT_AW-1:0] ext_idx;
	logic [15:0] ext_rdata;
	assign cmd = phs_cmd_t'(ctrl[PHS_CMD_MSB:PHS_CMD_LSB]); // see R18
	assign devad = ctrl[PHS_DEV_MSB:PHS_DEV_LSB];
	assign dev_ok = (devad == PHS_DEV_VEND) | (devad == PHS_DEV_MMD3)
		| (devad == PHS_DEV_MMD7); // see R19
	assign space = (devad == PHS_DEV_MMD3) ? 2'h1 :
		(devad == PHS_DEV_MMD7) ? 2'h2 : 2'h0;
	assign ext_idx = win_addr[EXT_AW-1:0];
	assign ext_rdata = dev_ok ? ext_mem[space][ext_idx] : 16'h0000; // see R19

	// Window access classification
	logic win_is_addr, win_wr, win_rd, win_wr_data, win_inc;
	logic [15:0] win_view;
	assign win_is_addr = (cmd == PHS_CMD_ADDR); // see R1
	assign win_wr = wr_done & hit_win & dev_ok; // see R19
	assign win_rd = rd_done & hit_win & dev_ok;
	assign win_wr_data = win_wr & ~win_is_addr;
	assign win_inc = (win_wr_data & (cmd != PHS_CMD_DATA))
		| (win_rd & (cmd == PHS_CMD_INC_RW)); // see R18
	assign win_view = win_is_addr ? win_addr : ext_rdata; // see R1

	// Byte-lane merge of a window write
	logic [15:0] win_merge_addr, win_merge_data;
	assign win_merge_addr = {wr_high ? pwdata[15:8] : win_addr[15:8],
		wr_low ? pwdata[7:0] : win_addr[7:0]};
	assign win_merge_data = {wr_high ? pwdata[15:8] : ext_rdata[15:8],
		wr_low ? pwdata[7:0] : ext_rdata[7:0]};

	// Next value of the extended address
	logic [15:0] next_win_addr;
	assign next_win_addr = (win_wr & win_is_addr) ? win_merge_addr :
		win_inc ? win_addr + 16'h0001 : win_addr; // see R18

	// Control register and extended address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= 16'h0000;
			win_addr <= PHS_WIN_RST;
		end else begin
			if (wr_done && hit_ctrl) begin
				ctrl[PHS_CMD_MSB:PHS_CMD_LSB] <= wr_high ? pwdata[PHS_CMD_MSB:PHS_CMD_LSB]
					: ctrl[PHS_CMD_MSB:PHS_CMD_LSB];
				ctrl[PHS_DEV_MSB:PHS_DEV_LSB] <= wr_low ? pwdata[PHS_DEV_MSB:PHS_DEV_LSB]
					: ctrl[PHS_DEV_MSB:PHS_DEV_LSB];
			end
			win_addr <= next_win_addr;
		end
	end

	// Extended register storage, no reset
	always_ff @(posedge pclk) begin
		if (win_wr_data) begin
			ext_mem[space][ext_idx] <= win_merge_data; // see R1
		end
	end

	// Fast link drop causes: set wins over the clearing read
	phs_fld_t fld_fire;
	logic fld_clr;
	logic [PHS_FLD_MSB-PHS_FLD_LSB:0] next_fld_cause;
	assign fld_fire = fld_enable & fld_cond & {5{link_drop}}; // see R3
	assign fld_clr = rd_done & hit_fld;
	assign next_fld_cause = (fld_clr ? '0 : fld_cause) | fld_fire; // see R3 R20

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fld_cause <= PHS_FLD_RST[PHS_FLD_MSB:PHS_FLD_LSB]; // see R3
		end else begin
			fld_cause <= next_fld_cause; // see R2
		end
	end

	// Status word read strobe, reloads the latch-low status bits
	logic sts_rd;
	assign sts_rd = rd_done & hit_sts;

	// Latch-high status bits, event wins over clear
	logic next_rxerr, next_pol, next_fcs, next_page, next_irq, next_rfault;
	assign next_rxerr = line_in.rx_err_evt
		| (st_rxerr & ~clr_in.rd_receive_error_counter); // see R5 R20
	assign next_pol = line_in.pol_inverted
		| (st_pol & ~clr_in.rd_ten_mbps_status_control); // see R6 R20
	assign next_fcs = line_in.false_carrier_evt
		| (st_fcs & ~clr_in.rd_false_carrier_counter); // see R7 R20
	assign next_page = line_in.page_rcvd_evt
		| (st_page & ~clr_in.rd_negotiation_expansion_reg); // see R10 R20
	assign next_irq = line_in.irq_pending
		| (st_irq & ~clr_in.rd_interrupt_status_reg); // see R11 R20
	assign next_rfault = line_in.remote_fault_evt
		| (st_rfault & ~clr_in.rd_basic_status_reg); // see R12 R20

	// Latch-low bits: a low level sticks until the status word is read
	logic next_sigdet, next_dlock;
	assign next_sigdet = line_in.signal_detect & (st_sigdet | sts_rd); // see R8 R20
	assign next_dlock = line_in.descr_lock & (st_dlock | sts_rd); // see R9 R20

	// Latched status bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_rxerr <= 1'b0;
			st_pol <= 1'b0;
			st_fcs <= 1'b0;
			st_sigdet <= 1'b0;
			st_dlock <= 1'b0;
			st_page <= 1'b0;
			st_irq <= 1'b0;
			st_rfault <= 1'b0;
		end else begin
			st_rxerr <= next_rxerr;
			st_pol <= next_pol;
			st_fcs <= next_fcs;
			st_sigdet <= next_sigdet;
			st_dlock <= next_dlock;
			st_page <= next_page;
			st_irq <= next_irq;
			st_rfault <= next_rfault;
		end
	end

	// Live copies, reading the status word never clears them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_mdix <= 1'b0;
			st_jab <= 1'b0;
			st_andone <= 1'b0;
			st_loop <= 1'b0;
			st_duplex <= 1'b0;
			st_speed <= PHS_SPEED_RST; // see R16
			st_link <= 1'b0;
		end else begin
			st_mdix <= line_in.mdix_swapped; // see R4
			st_jab <= line_in.jabber; // see R13
			st_andone <= line_in.an_complete; // see R14
			st_loop <= line_in.mii_loopback; // see R15
			st_duplex <= line_in.full_duplex; // see R15
			st_speed <= line_in.speed_10; // see R16
			st_link <= line_in.link_up; // see R17
		end
	end

	// Assembled read views
	logic [15:0] sts_word, fld_word;
	always_comb begin
		sts_word = 16'h0000;
		sts_word[PHS_ST_MDIX] = st_mdix;
		sts_word[PHS_ST_RXERR] = st_rxerr;
		sts_word[PHS_ST_POL] = st_pol;
		sts_word[PHS_ST_FCS] = st_fcs;
		sts_word[PHS_ST_SIGDET] = st_sigdet;
		sts_word[PHS_ST_DLOCK] = st_dlock;
		sts_word[PHS_ST_PAGE] = st_page;
		sts_word[PHS_ST_IRQ] = st_irq;
		sts_word[PHS_ST_RFAULT] = st_rfault;
		sts_word[PHS_ST_JAB] = st_jab;
		sts_word[PHS_ST_ANDONE] = st_andone;
		sts_word[PHS_ST_LOOP] = st_loop;
		sts_word[PHS_ST_DUPLEX] = st_duplex;
		sts_word[PHS_ST_SPEED] = st_speed;
		sts_word[PHS_ST_LINK] = st_link;
		fld_word = 16'h0000;
		fld_word[PHS_FLD_MSB:PHS_FLD_LSB] = fld_cause; // see R2
	end

	// Read mux
	logic [15:0] rd_mux;
	assign rd_mux = hit_ctrl ? ctrl :
		hit_win ? win_view :
		hit_fld ? fld_word :
		hit_sts ? sts_word : 16'h0000;

	// APB answer: one wait state, error on unmapped address
	logic next_pready;
	assign next_pready = psel & penable & ~pready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= next_pready;
			pslverr <= next_pready & ~hit_any;
			if (next_pready && !pwrite) begin
				prdata <= {16'h0000, rd_mux};
			end
		end
	end

endmodule
`default_nettype wire

// ---- tb_phs_status_regs.sv ----
// Self-checking bench for the status bank.
// Assumes the host model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_phs_status_regs import phs_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, link_drop, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	phs_line_t line_in;
	phs_clr_t clr_in;
	phs_fld_t fld_enable, fld_cond;
	logic [4:0] dv [3] = '{PHS_DEV_VEND, PHS_DEV_MMD3, PHS_DEV_MMD7};
	int n_mismatch = 0;
	int comparisons = 0;
	// Design and host
	phs_status_regs #(.EXT_AW(4), .PADDR_W(12)) phs_status_regs_inst (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .line_in,
		.clr_in, .fld_enable, .fld_cond, .link_drop);
	phs_apb_host phs_apb_host_inst (.pclk, .prdata, .pready, .pslverr, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb);
	// Compare and bus helpers
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic wr(input logic [9:0] i, input logic [15:0] d);
		phs_apb_host_inst.xfer(1'b1, i, {16'h0, d}, rd, err);
	endtask
	task automatic rdc(input logic [9:0] i, input logic [31:0] x, input string s);
		phs_apb_host_inst.xfer(1'b0, i, 32'h0, rd, err);
		chk(s, x, rd);
	endtask
	task automatic sel(input logic [1:0] c, input logic [4:0] d);
		wr(PHS_IDX_CTRL, {c, 9'h0, d});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Scenarios
	task automatic t_reset();
		rdc(PHS_IDX_WIN, {16'h0, PHS_WIN_RST}, "window");
		rdc(PHS_IDX_FLD, 32'h0, "cause");
		rdc(PHS_IDX_STS, 32'h2, "status");
		$display("test reset done");
	endtask
	task automatic t_window();
		foreach (dv[k]) begin
			sel(2'h0, dv[k]);
			wr(PHS_IDX_WIN, 16'h5);
			rdc(PHS_IDX_WIN, 32'h5, "address");
			sel(2'h1, dv[k]);
			wr(PHS_IDX_WIN, {11'h0, dv[k]});
		end
		foreach (dv[k]) begin
			sel(2'h0, dv[k]);
			wr(PHS_IDX_WIN, 16'h5);
			sel(2'h2, dv[k]);
			rdc(PHS_IDX_WIN, {27'h0, dv[k]}, "space data");
			sel(2'h0, dv[k]);
			rdc(PHS_IDX_WIN, 32'h6, "read increment");
			sel(2'h3, dv[k]);
			wr(PHS_IDX_WIN, {8'h12, 3'h0, dv[k]});
			sel(2'h0, dv[k]);
			rdc(PHS_IDX_WIN, 32'h7, "write increment");
			wr(PHS_IDX_WIN, 16'h6);
			sel(2'h3, dv[k]);
			rdc(PHS_IDX_WIN, {16'h0, 8'h12, 3'h0, dv[k]}, "write data");
			sel(2'h0, dv[k]);
			rdc(PHS_IDX_WIN, 32'h6, "no read increment");
		end
		// Unknown device address: write dropped, read zero, no increment
		sel(2'h2, 5'h02);
		wr(PHS_IDX_WIN, 16'hBEEF);
		rdc(PHS_IDX_WIN, 32'h0, "ignored device");
		sel(2'h0, 5'h02);
		rdc(PHS_IDX_WIN, 32'h6, "ignored increment");
		sel(2'h3, PHS_DEV_VEND);
		rdc(PHS_IDX_WIN, {16'h0, 8'h12, 3'h0, PHS_DEV_VEND}, "ignored write");
		$display("test window done");
	endtask
	task automatic t_cause();
		fld_enable <= 5'h1F;
		for (int i = 0; i < 5; i++) begin
			fld_cond <= phs_fld_t'(5'h01 << i);
			link_drop <= 1'b1;
			tick(1);
			link_drop <= 1'b0;
			rdc(PHS_IDX_FLD, 32'h10 << i, "cause bit");
			rdc(PHS_IDX_FLD, 32'h0, "cause cleared");
		end
		fld_enable <= 5'h0;
		link_drop <= 1'b1;
		tick(1);
		link_drop <= 1'b0;
		rdc(PHS_IDX_FLD, 32'h0, "disabled cause");
		fld_enable <= 5'h1F;
		tick(1);
		rdc(PHS_IDX_FLD, 32'h0, "no drop cause");
		$display("test cause done");
	endtask
	task automatic t_status();
		line_in <= 15'h7FFD;
		tick(2);
		rdc(PHS_IDX_STS, 32'h79FD, "status set");
		line_in <= 15'h463D;
		rdc(PHS_IDX_STS, 32'h7FFD, "status kept");
		clr_in <= 6'h3F;
		line_in <= 15'h663D;
		tick(1);
		clr_in <= 6'h0;
		line_in <= 15'h463D;
		tick(2);
		rdc(PHS_IDX_STS, 32'h663D, "status cleared");
		clr_in <= 6'h20;
		line_in <= 15'h403D;
		tick(1);
		clr_in <= 6'h0;
		tick(2);
		rdc(PHS_IDX_STS, 32'h403D, "latch low");
		line_in <= 15'h463D;
		tick(2);
		rdc(PHS_IDX_STS, 32'h403D, "latch low held");
		rdc(PHS_IDX_STS, 32'h463D, "latch low reload");
		$display("test status done");
	endtask
	task automatic t_unmapped();
		phs_apb_host_inst.xfer(1'b0, 10'h020, 32'h0, rd, err);
		chk("error flag", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		wr(PHS_IDX_STS, 16'hFFFF);
		rdc(PHS_IDX_STS, 32'h463D, "status write");
		$display("test unmapped done");
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Main sequence
	initial begin
		presetn = 1'b0;
		line_in = 15'h0002;
		clr_in = 6'h0;
		fld_enable = 5'h0;
		fld_cond = 5'h0;
		link_drop = 1'b0;
		tick(3);
		presetn <= 1'b1;
		tick(1);
		t_reset();
		t_window();
		t_cause();
		t_status();
		t_unmapped();
		// Second reset in mid run, bus idle
		line_in <= 15'h0002;
		presetn <= 1'b0;
		tick(3);
		presetn <= 1'b1;
		tick(1);
		t_reset();
		end_sim();
	end
	// Watchdog
	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end
endmodule
`default_nettype wire
